// *** rtl/dpa_alu.sv ***
// data processing execute stage: operand select, alu, flags and status commit
// Operation
// RQ1 - commit only when the condition passes the current flags
// RQ2 - condition comes from instruction bits 31 to 28
// RQ3 - opcodes 0010 to 0111 are the subtract and add forms
// RQ4 - logical opcodes and, xor, or, copy, bit clear, inverted copy
// RQ5 - opcodes 1000 to 1011 only set flags, never write destination
// RQ6 - first operand a register; immediate bit picks the second operand
// RQ7 - logical flags: v kept, c from shifter, z on zero, n bit 31
// RQ8 - arithmetic flags: v signed overflow, c adder carry, z zero, n bit 31
// RQ9 - shift amount from 5-bit field or low byte of a register
// RQ10 - left shift fills zeros, last bit out is the carry
// RQ11 - immediate left shift by zero passes operand with old carry
// RQ12 - immediate right shift field zero means shift by 32
// RQ13 - arithmetic right shift sign fills; field zero means 32
// RQ14 - rotate with field zero rotates carry and operand by one
// RQ15 - register amount uses low byte; zero passes with old carry
// RQ16 - register left shift of 32 or more: zero, carry bit 0 or zero
// RQ17 - register right shift of 32 or more: zero, carry bit 31 or zero
// RQ18 - register arithmetic shift of 32 or more fills with bit 31
// RQ19 - register rotate by 32 multiples returns operand, carry bit 31
// RQ20 - register shift with bit 7 set is not a data operation
// RQ21 - immediate is a zero-extended byte rotated right by twice the field
// RQ22 - pc destination without flag bit writes pc, status untouched
// RQ23 - pc destination with flag bit writes pc and restores saved status
// RQ24 - pc operand reads address plus 8, or plus 12 for register amount
// RQ25 - legacy test form restores saved status when privileged, else nothing
// RQ26 - shifter result and carry ready in the execute cycle
//
// The plain strobed port and the register addresses are this design's own decisions.
`default_nettype none

module dpa_alu (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic instr_valid_in,
  input wire logic [dpa_pkg::DW-1:0] instr_in,
  input wire logic [dpa_pkg::DW-1:0] instr_addr_in,
  input wire logic [dpa_pkg::DW-1:0] first_operand_reg_in,
  input wire logic [dpa_pkg::DW-1:0] shifted_operand_reg_in,
  input wire logic [dpa_pkg::DW-1:0] shift_amount_reg_in,
  input wire logic [dpa_pkg::AW-1:0] reg_addr_in,
  input wire logic [dpa_pkg::DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [dpa_pkg::DW-1:0] reg_rdata_out,
  output logic [dpa_pkg::DW-1:0] result_out,
  output logic [3:0] dest_idx_out,
  output logic dest_wr_out,
  output logic pc_wr_out,
  output logic undef_out,
  output logic [dpa_pkg::DW-1:0] current_status_word_out
);
  import dpa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // one entry per condition group; odd codes take the inverse
  function automatic logic cond_pass(input logic [3:0] c, input logic [DW-1:0] sw);
    logic base;
    base = 1'b1;
    case (c[3:1])
      CG_ZERO: base = sw[FLG_Z];
      CG_CARRY: base = sw[FLG_C];
      CG_NEG: base = sw[FLG_N];
      CG_OVF: base = sw[FLG_V];
      CG_HIGHER: base = sw[FLG_C] && !sw[FLG_Z];
      CG_GE: base = (sw[FLG_N] == sw[FLG_V]);
      CG_GT: base = !sw[FLG_Z] && (sw[FLG_N] == sw[FLG_V]);
      default: base = 1'b1;
    endcase
    // reserved 1111 falls out as never
    return c[0] ? !base : base;
  endfunction

  // the adder-based opcodes, test forms included
  function automatic logic is_arith(input logic [3:0] opc);
    return (opc >= minus_op && opc <= reverse_minus_borrow_op) ||
           opc == compare_op || opc == compare_negated_op;
  endfunction

  // a register index of 15 reads the prefetch-adjusted address
  function automatic logic [DW-1:0] reg_or_pc(input logic [3:0] idx, input logic [DW-1:0] v,
                                              input logic [DW-1:0] pc);
    return (idx == PC_REG) ? pc : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and decode

  dpa_state_t st_r;
  dpa_state_t st_nxt;

  logic [3:0] cond;
  logic [3:0] opc;
  logic [3:0] rd;
  logic [3:0] rn;
  logic [3:0] rm;
  logic imm_sel;
  logic set_flags;
  logic reg_shift;
  logic is_dp;
  logic bad_form;
  logic cond_ok;
  logic is_test;
  logic user_mode;

  // field extraction
  assign cond = instr_in[F_COND_HI:F_COND_LO]; // see RQ2
  assign opc = instr_in[F_OPC_HI:F_OPC_LO];
  assign rd = instr_in[F_RD_HI:F_RD_LO];
  assign rn = instr_in[F_RN_HI:F_RN_LO];
  assign rm = instr_in[F_RM_HI:F_RM_LO];
  assign imm_sel = instr_in[F_IMM_SEL];
  assign set_flags = instr_in[F_SET];
  assign reg_shift = !imm_sel && instr_in[F_SREG];
  assign is_dp = instr_valid_in && (instr_in[F_CLASS_HI:F_CLASS_LO] == CLASS_DP);
  assign bad_form = reg_shift && instr_in[F_MUL_BIT]; // see RQ20
  assign cond_ok = cond_pass(cond, st_r.status); // see RQ1
  assign is_test = (opc[3:2] == TEST_GRP);
  assign user_mode = (st_r.status[MODE_HI:MODE_LO] == MODE_USER);

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch and second operand

  logic [DW-1:0] pc_val;
  logic [DW-1:0] op1;
  logic [DW-1:0] opm;
  logic [AMT_W-1:0] sh_amt;
  logic [DW-1:0] sh_res;
  logic sh_c;
  logic [DW-1:0] imm_wide;
  logic [ROT_W-1:0] imm_rot;
  logic [2*DW-1:0] imm_dbl;
  logic [DW-1:0] imm_val;
  logic imm_c;
  logic [DW-1:0] op2;
  logic op2_c;

  // a register-held amount costs one more prefetch word
  assign pc_val = instr_addr_in + (reg_shift ? PC_OFS_REG : PC_OFS_IMM); // see RQ24
  assign op1 = reg_or_pc(rn, first_operand_reg_in, pc_val); // see RQ6 see RQ24
  assign opm = reg_or_pc(rm, shifted_operand_reg_in, pc_val);

  // low byte of the amount register only; index 15 not substituted
  assign sh_amt = reg_shift ? shift_amount_reg_in[AMT_W-1:0] :
                  {3'h0, instr_in[F_SAMT_HI:F_SAMT_LO]}; // see RQ9 see RQ15

  dpa_shifter u_shifter (
    .operand_in(opm),
    .amount_in(sh_amt),
    .type_in(instr_in[F_STYPE_HI:F_STYPE_LO]),
    .imm_form_in(!reg_shift),
    .carry_in(st_r.status[FLG_C]),
    .result_out(sh_res),
    .carry_out(sh_c)
  );

  // rotated immediate; an unrotated byte keeps the old carry
  assign imm_wide = {24'h0, instr_in[F_IMM_HI:F_IMM_LO]};
  assign imm_rot = {instr_in[F_ROT_HI:F_ROT_LO], 1'b0};
  assign imm_dbl = {imm_wide, imm_wide} >> imm_rot;
  assign imm_val = imm_dbl[DW-1:0]; // see RQ21
  assign imm_c = (imm_rot == '0) ? st_r.status[FLG_C] : imm_val[DW-1];

  // select the second operand by the immediate bit
  assign op2 = imm_sel ? imm_val : sh_res; // see RQ6
  assign op2_c = imm_sel ? imm_c : sh_c;

  ////////////////////////////////////////////////////////////////////////////
  // alu: one shared adder, operands swapped or inverted per opcode

  logic [DW-1:0] add_x;
  logic [DW-1:0] add_y;
  logic add_cin;
  logic [DW:0] sum;
  logic add_v;
  logic [DW-1:0] alu_res;

  always_comb begin
    add_x = op1;
    add_y = op2;
    add_cin = 1'b0;
    // subtract is x plus not y plus one; borrow forms use the carry for the one
    case (opc)
      minus_op, compare_op: begin
        add_y = ~op2;
        add_cin = 1'b1;
      end
      reverse_minus_op: begin
        add_x = op2;
        add_y = ~op1;
        add_cin = 1'b1;
      end
      add_carry_op: add_cin = st_r.status[FLG_C];
      minus_with_borrow_op: begin
        add_y = ~op2;
        add_cin = st_r.status[FLG_C];
      end
      reverse_minus_borrow_op: begin
        add_x = op2;
        add_y = ~op1;
        add_cin = st_r.status[FLG_C];
      end
      default: add_cin = 1'b0;
    endcase
  end

  assign sum = {1'b0, add_x} + {1'b0, add_y} + {{DW{1'b0}}, add_cin}; // see RQ3
  // overflow when like-signed inputs give a differently signed sum
  assign add_v = (add_x[DW-1] == add_y[DW-1]) && (sum[DW-1] != add_x[DW-1]); // see RQ8

  // result mux
  always_comb begin
    case (opc)
      and_op, test_bits_op: alu_res = op1 & op2; // see RQ4 see RQ5
      exclusive_or_op, test_equivalence_op: alu_res = op1 ^ op2; // see RQ4 see RQ5
      bitwise_or_op: alu_res = op1 | op2; // see RQ4
      copy_second_operand_op: alu_res = op2; // see RQ4
      bit_clear_op: alu_res = op1 & ~op2; // see RQ4
      copy_inverted_op: alu_res = ~op2; // see RQ4
      default: alu_res = sum[DW-1:0]; // see RQ3 see RQ5
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next flags from the result

  logic [3:0] new_flags;

  always_comb begin
    new_flags[3] = alu_res[DW-1]; // see RQ7 see RQ8
    new_flags[2] = (alu_res == '0); // see RQ7 see RQ8
    // logical class keeps overflow and takes the shifter carry
    new_flags[1] = is_arith(opc) ? sum[DW] : op2_c; // see RQ7 see RQ8
    new_flags[0] = is_arith(opc) ? add_v : st_r.status[FLG_V]; // see RQ7 see RQ8
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port and commit

  always_comb begin
    st_nxt = st_r;
    st_nxt.dest_wr = 1'b0;
    st_nxt.pc_wr = 1'b0;
    st_nxt.undef = 1'b0;
    st_nxt.rd_data = '0;
    // reads return the value before any write of the same cycle
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_STATUS: st_nxt.rd_data = st_r.status;
        REG_SAVED: st_nxt.rd_data = st_r.saved;
        REG_RESULT: st_nxt.rd_data = st_r.result;
        default: st_nxt.rd_data = '0;
      endcase
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_STATUS: st_nxt.status = reg_wdata_in;
        REG_SAVED: st_nxt.saved = reg_wdata_in;
        default: st_nxt.saved = st_r.saved;
      endcase
    end
    // an executing instruction beats a port write to status
    if (is_dp && bad_form) begin
      st_nxt.undef = 1'b1; // see RQ20
    end else if (is_dp && cond_ok) begin // see RQ1
      st_nxt.result = alu_res;
      st_nxt.dest_idx = rd;
      if (is_test) begin
        if (rd == PC_REG) begin
          // legacy restore form: user mode has no saved word to take
          if (!user_mode) begin
            st_nxt.status = st_r.saved; // see RQ25
          end
        end else begin
          st_nxt.status[FLG_N:FLG_V] = new_flags; // see RQ5
        end
      end else if (rd == PC_REG) begin
        st_nxt.pc_wr = 1'b1; // see RQ22 see RQ23
        if (set_flags) begin
          // pc and status change on one edge: atomic restore
          st_nxt.status = st_r.saved; // see RQ23
        end
      end else begin
        st_nxt.dest_wr = 1'b1;
        if (set_flags) begin
          st_nxt.status[FLG_N:FLG_V] = new_flags; // see RQ7 see RQ8
        end
      end
    end
    if (srst_in) begin
      st_nxt = '0;
      st_nxt.status = CSW_RESET;
    end
  end

  // single state register
  always_ff @(posedge ref_clk_in) begin
    st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign reg_rdata_out = st_r.rd_data;
  assign result_out = st_r.result;
  assign dest_idx_out = st_r.dest_idx;
  assign dest_wr_out = st_r.dest_wr;
  assign pc_wr_out = st_r.pc_wr;
  assign undef_out = st_r.undef;
  assign current_status_word_out = st_r.status;
endmodule

`default_nettype wire

// *** rtl/dpa_pkg.sv ***
// shared constants and types of the data processing datapath
`default_nettype none

package dpa_pkg;
  localparam int DW = 32;
  localparam int AMT_W = 8;
  localparam int STYPE_W = 2;
  localparam int ROT_W = 5;
  localparam int CLAMP_W = 6;
  localparam int AW = 8;

  // instruction word fields
  localparam int F_COND_HI = 31;
  localparam int F_COND_LO = 28;
  localparam int F_CLASS_HI = 27;
  localparam int F_CLASS_LO = 26;
  localparam int F_IMM_SEL = 25;
  localparam int F_OPC_HI = 24;
  localparam int F_OPC_LO = 21;
  localparam int F_SET = 20;
  localparam int F_RN_HI = 19;
  localparam int F_RN_LO = 16;
  localparam int F_RD_HI = 15;
  localparam int F_RD_LO = 12;
  localparam int F_SAMT_HI = 11;
  localparam int F_SAMT_LO = 7;
  localparam int F_MUL_BIT = 7;
  localparam int F_STYPE_HI = 6;
  localparam int F_STYPE_LO = 5;
  localparam int F_SREG = 4;
  localparam int F_RM_HI = 3;
  localparam int F_RM_LO = 0;
  localparam int F_ROT_HI = 11;
  localparam int F_ROT_LO = 8;
  localparam int F_IMM_HI = 7;
  localparam int F_IMM_LO = 0;
  localparam logic [1:0] CLASS_DP = 2'h0;

  // status word layout
  localparam int FLG_N = 31;
  localparam int FLG_Z = 30;
  localparam int FLG_C = 29;
  localparam int FLG_V = 28;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 0;
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [DW-1:0] CSW_RESET = 32'h0000_0013;

  localparam logic [3:0] PC_REG = 4'hf;
  localparam logic [DW-1:0] PC_OFS_IMM = 32'h0000_0008;
  localparam logic [DW-1:0] PC_OFS_REG = 32'h0000_000c;

  // opcodes
  localparam logic [3:0] and_op = 4'h0;
  localparam logic [3:0] exclusive_or_op = 4'h1;
  localparam logic [3:0] minus_op = 4'h2;
  localparam logic [3:0] reverse_minus_op = 4'h3;
  localparam logic [3:0] add_op = 4'h4;
  localparam logic [3:0] add_carry_op = 4'h5;
  localparam logic [3:0] minus_with_borrow_op = 4'h6;
  localparam logic [3:0] reverse_minus_borrow_op = 4'h7;
  localparam logic [3:0] test_bits_op = 4'h8;
  localparam logic [3:0] test_equivalence_op = 4'h9;
  localparam logic [3:0] compare_op = 4'ha;
  localparam logic [3:0] compare_negated_op = 4'hb;
  localparam logic [3:0] bitwise_or_op = 4'hc;
  localparam logic [3:0] copy_second_operand_op = 4'hd;
  localparam logic [3:0] bit_clear_op = 4'he;
  localparam logic [3:0] copy_inverted_op = 4'hf;
  localparam logic [1:0] TEST_GRP = 2'h2;

  // shift kinds
  localparam logic [1:0] logical_left_shift = 2'h0;
  localparam logic [1:0] logical_right_shift = 2'h1;
  localparam logic [1:0] arithmetic_right_shift = 2'h2;
  localparam logic [1:0] rotate_right = 2'h3;
  localparam logic [AMT_W-1:0] SH_FULL = 8'h20;
  localparam logic [CLAMP_W-1:0] SH_CLAMP = 6'h20;

  // condition groups, low condition bit inverts
  localparam logic [2:0] CG_ZERO = 3'h0;
  localparam logic [2:0] CG_CARRY = 3'h1;
  localparam logic [2:0] CG_NEG = 3'h2;
  localparam logic [2:0] CG_OVF = 3'h3;
  localparam logic [2:0] CG_HIGHER = 3'h4;
  localparam logic [2:0] CG_GE = 3'h5;
  localparam logic [2:0] CG_GT = 3'h6;

  // register port offsets
  localparam logic [AW-1:0] REG_STATUS = 8'h00;
  localparam logic [AW-1:0] REG_SAVED = 8'h04;
  localparam logic [AW-1:0] REG_RESULT = 8'h08;

  typedef struct packed {
    logic [DW-1:0] status;
    logic [DW-1:0] saved;
    logic [DW-1:0] result;
    logic [DW-1:0] rd_data;
    logic [3:0] dest_idx;
    logic dest_wr;
    logic pc_wr;
    logic undef;
  } dpa_state_t;
endpackage

`default_nettype wire

// *** rtl/dpa_shifter.sv ***
// barrel shifter producing the second operand and its carry-out
`default_nettype none

module dpa_shifter (
  input wire logic [dpa_pkg::DW-1:0] operand_in,
  input wire logic [dpa_pkg::AMT_W-1:0] amount_in,
  input wire logic [dpa_pkg::STYPE_W-1:0] type_in,
  input wire logic imm_form_in,
  input wire logic carry_in,
  output logic [dpa_pkg::DW-1:0] result_out,
  output logic carry_out
);
  import dpa_pkg::*;

  logic [AMT_W-1:0] n;
  logic pass;
  logic rotate_through_carry;
  logic [CLAMP_W-1:0] asr_n;
  logic [2*DW-1:0] lsl_w;
  logic [2*DW-1:0] lsr_w;
  logic [2*DW-1:0] asr_w;
  logic [2*DW-1:0] ror_w;

  ////////////////////////////////////////////////////////////////////////////
  // purely combinational so flags see the carry in the same cycle (see RQ26)
  always_comb begin
    pass = (amount_in == '0) && (!imm_form_in || type_in == logical_left_shift); // see RQ11 see RQ15
    rotate_through_carry = imm_form_in && (amount_in == '0) && (type_in == rotate_right); // see RQ14
    n = (imm_form_in && amount_in == '0) ? SH_FULL : amount_in; // see RQ12 see RQ13
    // anything at or past 32 gives pure sign fill
    asr_n = (n >= SH_FULL) ? SH_CLAMP : n[CLAMP_W-1:0]; // see RQ18
    // wide shifts: the bit just past the kept word is the carry; rotate takes bit 31 of the kept word
    lsl_w = {{DW{1'b0}}, operand_in} << n; // see RQ10 see RQ16
    lsr_w = {operand_in, {DW{1'b0}}} >> n; // see RQ17
    asr_w = $unsigned($signed({operand_in, {DW{1'b0}}}) >>> asr_n); // see RQ13
    ror_w = {operand_in, operand_in} >> n[ROT_W-1:0]; // see RQ19
    result_out = operand_in;
    carry_out = carry_in;
    if (rotate_through_carry) begin
      result_out = {carry_in, operand_in[DW-1:1]};
      carry_out = operand_in[0];
    end else if (!pass) begin
      case (type_in)
        logical_left_shift: begin
          result_out = lsl_w[DW-1:0];
          carry_out = lsl_w[DW];
        end
        logical_right_shift: begin
          result_out = lsr_w[2*DW-1:DW];
          carry_out = lsr_w[DW-1];
        end
        arithmetic_right_shift: begin
          result_out = asr_w[2*DW-1:DW];
          carry_out = asr_w[DW-1];
        end
        default: begin
          // multiples of 32 leave the word whole with bit 31 as carry
          result_out = ror_w[DW-1:0];
          carry_out = ror_w[DW-1];
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// *** test/dpa_alu_properties.sv ***
// port checks of the execute stage, bound into its top
`default_nettype none
module dpa_alu_checker import dpa_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic instr_valid_in,
  input wire logic [DW-1:0] instr_in,
  input wire logic [DW-1:0] instr_addr_in,
  input wire logic [DW-1:0] shifted_operand_reg_in,
  input wire logic reg_wr_in,
  input wire logic [DW-1:0] result_out,
  input wire logic [3:0] dest_idx_out,
  input wire logic dest_wr_out,
  input wire logic pc_wr_out,
  input wire logic undef_out,
  input wire logic [DW-1:0] current_status_word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////
  // decode helpers; run means an always-condition data operation
  wire logic dpv = instr_valid_in && instr_in[27:26] == CLASS_DP;
  wire logic run = dpv && instr_in[31:28] == 4'he;
  wire logic bad = !instr_in[25] && instr_in[4] && instr_in[7];
  wire logic [4:0] op_s = instr_in[24:20];
  wire logic [3:0] rd = instr_in[15:12];
  wire logic [31:0] imm8 = {24'h0, instr_in[7:0]};
  wire logic [4:0] rot2 = {instr_in[11:8], 1'b0};
  // a zero rotate shifts left by 32 and adds nothing
  wire logic [31:0] imm_rot = (imm8 >> rot2) | (imm8 << (6'h20 - {1'b0, rot2}));
  wire logic [31:0] shl = shifted_operand_reg_in << instr_in[11:7];
  ////////////////////////////////////////////////////////////
  never_cond_a: assert property (
    dpv && &instr_in[31:28] |=> !dest_wr_out && !pc_wr_out) else $error("never condition committed");
  test_no_write_a: assert property (
    run && op_s[4:3] == 2'b10 |=> !dest_wr_out) else $error("test op wrote");
  undef_pulse_a: assert property (
    dpv && bad |=> undef_out && !dest_wr_out && !pc_wr_out) else $error("bit 7 form executed");
  imm_copy_a: assert property (
    run && instr_in[25] && op_s[4:1] == 4'hd && rd != PC_REG |=> dest_wr_out && result_out == $past(imm_rot)
    && dest_idx_out == $past(rd)) else $error("bad immediate");
  pc_plain_a: assert property (
    run && !bad && op_s == 5'h1a && rd == PC_REG && !reg_wr_in |=> pc_wr_out && !dest_wr_out
    && $stable(current_status_word_out)) else $error("bad pc write");
  dest_not_pc_a: assert property (
    dest_wr_out |-> dest_idx_out != PC_REG && !pc_wr_out && $past(instr_valid_in))
    else $error("bad destination pulse");
  copy_flags_a: assert property (
    run && !instr_in[25] && instr_in[11:4] == 8'h00 && op_s == 5'h1b && rd != PC_REG && instr_in[3:0] != PC_REG
    && !reg_wr_in |=> result_out == $past(shifted_operand_reg_in) && current_status_word_out[31] == result_out[31]
    && current_status_word_out[29:0] == $past(current_status_word_out[29:0])
    && current_status_word_out[30] == (result_out == 32'h0)) else $error("logical flags wrong");
  pc_operand_a: assert property (
    run && instr_in[25] && op_s == 5'h08 && instr_in[19:16] == PC_REG && rd != PC_REG
    |=> result_out == $past(instr_addr_in) + PC_OFS_IMM + $past(imm_rot)) else $error("pc operand wrong");
  lsl_imm_a: assert property (
    run && !instr_in[25] && instr_in[6:4] == 3'h0 && instr_in[11:7] != 5'h0 && op_s[4:1] == 4'hd
    && rd != PC_REG && instr_in[3:0] != PC_REG |=> dest_wr_out && result_out == $past(shl))
    else $error("left shift wrong");
endmodule
bind dpa_alu dpa_alu_checker chk_u (.*);
`default_nettype wire

// *** test/dpa_regfile_model.sv ***
// register file partner
`default_nettype none
module dpa_regfile_model (
  input wire logic ref_clk_in,
  input wire logic [31:0] instr_in,
  input wire logic ld_in,
  input wire logic [31:0] ld_a_in,
  input wire logic [31:0] ld_b_in,
  input wire logic dest_wr_in,
  input wire logic [3:0] dest_idx_in,
  input wire logic [31:0] result_in,
  output logic [31:0] rn_out,
  output logic [31:0] rm_out,
  output logic [31:0] rs_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [16];
  // combinational reads track the instruction word
  assign rn_out = regs[instr_in[19:16]];
  assign rm_out = regs[instr_in[3:0]];
  assign rs_out = regs[instr_in[11:8]];
  // bench loads fill r2 to r4; write-backs otherwise
  always_ff @(posedge ref_clk_in) begin
    if (ld_in) begin
      regs[2] <= ld_a_in;
      regs[3] <= ld_b_in;
      regs[4] <= ld_a_in;
    end
    if (dest_wr_in) begin
      regs[dest_idx_in] <= result_in;
    end
  end
endmodule
`default_nettype wire

// *** test/dpa_alu_test.sv ***
// self-checking bench for the data processing execute stage
`default_nettype none
module dpa_alu_test;
  import dpa_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] io;
    logic [11:0] op2;
    logic [31:0] a;
    logic [31:0] b;
    logic [3:0] fin;
    logic [31:0] res;
    logic [3:0] fout;
  } dpa_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic valid = 1'b0, wr = 1'b0, rd = 1'b0, ld = 1'b0;
  logic [31:0] instr, iaddr, wdata, la, lb;
  logic [7:0] raddr = 8'h00;
  logic [31:0] rn_v, rm_v, rs_v, rdata, result, csw, v;
  logic [3:0] didx;
  logic dwr, pcwr, undef;
  int n_fail = 0;
  int cmp_count = 0;
  // io, op2, a in r2/r4, b in r3, flags in, result, flags out
  dpa_row_t rows [29] = '{
    '{5'h00,12'h003,32'hff00ff00,32'h0ff00ff0,4'h2,32'h0f000f00,4'h2},
    '{5'h01,12'h003,32'hffffffff,32'hffffffff,4'h1,32'h0,4'h5},
    '{5'h02,12'h003,32'h5,32'h7,4'h0,32'hfffffffe,4'h8},
    '{5'h03,12'h003,32'h5,32'h7,4'h0,32'h2,4'h2},
    '{5'h04,12'h003,32'h7fffffff,32'h1,4'h0,32'h80000000,4'h9},
    '{5'h05,12'h003,32'hffffffff,32'h0,4'h2,32'h0,4'h6},
    '{5'h06,12'h003,32'h0,32'h0,4'h0,32'hffffffff,4'h8},
    '{5'h07,12'h003,32'h1,32'h80000000,4'h2,32'h7fffffff,4'h3},
    '{5'h08,12'h003,32'hf,32'hf0,4'h2,32'h0,4'h6},
    '{5'h09,12'h003,32'h80000000,32'h0,4'h0,32'h80000000,4'h8},
    '{5'h0a,12'h003,32'h3,32'h3,4'h0,32'h0,4'h6},
    '{5'h0b,12'h003,32'hffffffff,32'h1,4'h0,32'h0,4'h6},
    '{5'h0c,12'h003,32'hf,32'hf0,4'h0,32'hff,4'h0},
    '{5'h1d,12'h4ff,32'h12345678,32'h0,4'h0,32'hff000000,4'ha},
    '{5'h0e,12'h003,32'hff,32'hf,4'h0,32'hf0,4'h0},
    '{5'h0f,12'h003,32'h5,32'h0,4'h0,32'hffffffff,4'h8},
    '{5'h0d,12'h003,32'h0,32'h0,4'h3,32'h0,4'h7},
    '{5'h0d,12'h083,32'h0,32'h80000001,4'h0,32'h2,4'h2},
    '{5'h0d,12'h023,32'h0,32'h80000001,4'h0,32'h0,4'h6},
    '{5'h0d,12'h043,32'h0,32'h80000001,4'h0,32'hffffffff,4'ha},
    '{5'h0d,12'h063,32'h0,32'h80000001,4'h2,32'hc0000000,4'ha},
    '{5'h0d,12'h413,32'h100,32'h80000001,4'h2,32'h80000001,4'ha},
    '{5'h0d,12'h413,32'h20,32'h80000001,4'h0,32'h0,4'h6},
    '{5'h0d,12'h413,32'h21,32'h80000001,4'h2,32'h0,4'h4},
    '{5'h0d,12'h433,32'h20,32'h80000001,4'h0,32'h0,4'h6},
    '{5'h0d,12'h433,32'h28,32'h80000001,4'h2,32'h0,4'h4},
    '{5'h0d,12'h453,32'hc8,32'h80000001,4'h0,32'hffffffff,4'ha},
    '{5'h0d,12'h473,32'h20,32'h80000001,4'h0,32'h80000001,4'ha},
    '{5'h0d,12'h473,32'h24,32'h80000001,4'h0,32'h18000000,4'h0}};
  // free-running 20 MHz clock
  always #25 clk = ~clk;
  dpa_alu dut_u (.ref_clk_in(clk), .srst_in(srst), .instr_valid_in(valid), .instr_in(instr),
    .instr_addr_in(iaddr), .first_operand_reg_in(rn_v), .shifted_operand_reg_in(rm_v),
    .shift_amount_reg_in(rs_v), .reg_addr_in(raddr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .result_out(result), .dest_idx_out(didx),
    .dest_wr_out(dwr), .pc_wr_out(pcwr), .undef_out(undef), .current_status_word_out(csw));
  dpa_regfile_model rf_u (.ref_clk_in(clk), .instr_in(instr), .ld_in(ld), .ld_a_in(la), .ld_b_in(lb),
    .dest_wr_in(dwr), .dest_idx_in(didx), .result_in(result), .rn_out(rn_v), .rm_out(rm_v), .rs_out(rs_v));
  ////////////////////////////////////////////////////////////
  // comparison, verdict and bus helpers
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    raddr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand one cycle after the strobe; sample at that negedge
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    raddr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // operands and flags load together before the instruction
  task automatic setup(input logic [31:0] a, b, input logic [3:0] f);
    @(posedge clk);
    ld <= 1'b1;
    la <= a;
    lb <= b;
    wr <= 1'b1;
    raddr <= REG_STATUS;
    wdata <= {f, 28'h0000013};
    @(posedge clk);
    ld <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic issue(input logic [31:0] w);
    @(posedge clk);
    valid <= 1'b1;
    instr <= w;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
  endtask
  function automatic logic [31:0] dp(input logic [3:0] c, logic [4:0] io, logic s, logic [3:0] n, d,
      logic [11:0] op2);
    return {c, 2'b00, io, s, n, d, op2};
  endfunction
  ////////////////////////////////////////////////////////////
  // hang guard, far past the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
  // reset, table rows, then awkward cases
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(csw, CSW_RESET);
    foreach (rows[i]) begin
      setup(rows[i].a, rows[i].b, rows[i].fin);
      issue(dp(4'he, rows[i].io, 1'b1, 4'h2, 4'h1, rows[i].op2));
      chk(result, rows[i].res);
      chk(32'(csw[31:28]), 32'(rows[i].fout));
      chk(32'(dwr), 32'(rows[i].io[3:2] != 2'b10));
    end
    // every condition code against all-clear and all-set flags
    for (int k = 0; k < 32; k++) begin
      setup(32'h1, 32'h0, k[4] ? 4'hf : 4'h0);
      issue(dp(k[3:0], 5'h04, 1'b0, 4'h2, 4'h1, 12'h003));
      chk(32'(dwr), 32'(((k[4] ? 16'h6655 : 16'h56aa) >> k[3:0]) & 16'h1));
    end
    @(posedge clk);
    iaddr <= 32'h0000_0100;
    setup(32'h0, 32'h0, 4'h0);
    issue(dp(4'he, 5'h14, 1'b0, 4'hf, 4'h1, 12'h000));
    chk(result, 32'h0000_0108);
    issue(dp(4'he, 5'h0d, 1'b0, 4'h0, 4'h1, 12'h41f));
    chk(result, 32'h0000_010c);
    issue(dp(4'he, 5'h0d, 1'b0, 4'h2, 4'h1, 12'h493));
    chk(32'({undef, dwr}), 32'h2);
    setup(32'h0, 32'h200, 4'h0);
    issue(dp(4'he, 5'h0d, 1'b0, 4'h0, 4'hf, 12'h003));
    chk(32'({pcwr, dwr}), 32'h2);
    chk(csw, 32'h0000_0013);
    wreg(REG_SAVED, 32'h9000_001f);
    issue(dp(4'he, 5'h0d, 1'b1, 4'h0, 4'hf, 12'h003));
    chk(32'(pcwr), 32'h1);
    chk(csw, 32'h9000_001f);
    // result register is read-only; unmapped reads give zero
    wreg(REG_RESULT, 32'h5555_5555);
    rreg(REG_RESULT);
    chk(v, 32'h0000_0200);
    rreg(8'h0c);
    chk(v, 32'h0);
    wreg(REG_SAVED, 32'h4000_0011);
    issue(dp(4'he, 5'h09, 1'b1, 4'h2, 4'hf, 12'h003));
    chk(csw, 32'h4000_0011);
    wreg(REG_STATUS, 32'h0000_0010);
    issue(dp(4'he, 5'h09, 1'b1, 4'h2, 4'hf, 12'h003));
    rreg(REG_STATUS);
    chk(v, 32'h0000_0010);
    report_and_stop;
  end
endmodule
`default_nettype wire
